/* File: core/boac_pkg.sv */
// Constants and carrier types for the beacon option and alarm block.
// Assumes a single 200 MHz clock and an APB register port on the host side.
//
// How it works
// - Switch 1 on forwards red alarm on sync
// - Switches 2-4 give multidrop address, zero disables
// - Nonzero address selects RS-485, disables modem
// - Base model ignores address switches entirely
// - Switches 5-7 give expected marker count
// - Fewer detected markers than set raises alarm
// - No photocell day/night change in 19h alarms, master only
// - Red alarm is night error OR photocell alarm
// - Valid flash lights flash-detected indicator
// - Marker indicator lit while marker output driven
// - Serial traffic pulses transmit/receive indicators
// - DCD indicator held while modem connected
// - Open jumper means master using photocell
// - Master pulses sync; all units flash on it
package boac_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // CTRL fields
  localparam int CTRL_BASE_MODEL = 0;
  localparam int CTRL_NIGHT_INTENSITY_ERROR = 1;
  localparam int CTRL_SYNC_GEN = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt status bits
  localparam int IRQ_MARKER = 0;
  localparam int IRQ_PHOTO = 1;
  localparam int IRQ_RED = 2;
  localparam int IRQ_FLASH = 3;
  localparam int IRQ_W = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 200_000_000;
  localparam longint PHOTO_TIMEOUT_HOURS = 19;
  localparam longint PHOTO_TIMEOUT_CYC = PHOTO_TIMEOUT_HOURS * 3600 * CLK_HZ;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * 200;
  localparam int LED_PULSE_MS = 50;
  localparam int LED_PULSE_CYC = LED_PULSE_MS * 200_000;
  localparam int SYNC_PERIOD_MS = 3000;
  localparam longint SYNC_PERIOD_CYC = longint'(SYNC_PERIOD_MS) * 200_000;
  localparam int SYNC_WIDTH_US = 100;
  localparam int SYNC_WIDTH_CYC = SYNC_WIDTH_US * 200;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic alarm_report;
    logic [2:0] address;
    logic [2:0] markers;
    logic slave_mode;
  } boac_cfg_t;

  typedef struct packed {
    logic red;
    logic photo;
    logic marker;
  } boac_alarm_t;

  typedef struct packed {
    logic flash_det;
    logic marker_out;
    logic tx;
    logic rx;
    logic dcd;
    logic red_alarm;
    logic photo_alarm;
    logic marker_alarm;
  } boac_led_t;

  function automatic logic [2:0] boac_marker_count(input logic [2:0] sw);
    boac_marker_count = (sw == 3'h7) ? 3'h6 : sw;
  endfunction : boac_marker_count

endpackage : boac_pkg

/* File: core/boac_debounce.sv */
// Two-flop synchroniser plus a stable-time debounce filter for slow inputs.
// Assumes inputs are mechanical switches or jumpers on board pins.
`timescale 1ns/100ps
module boac_debounce #(
  parameter int W = 8,
  parameter int CYC = 1000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;
  logic [W-1:0] clean_r;
  logic [31:0] cnt_r;
  wire changed = (sync_r != last_r);
  wire settled = (cnt_r == 32'(CYC - 1));

  // Switch bounce is slow, so a single shared counter restarting on any change is enough
  always_ff @(posedge mclk) begin
    meta_r <= raw;
    sync_r <= meta_r;
    if (reset) begin
      last_r <= '0;
      clean_r <= '0;
      cnt_r <= '0;
    end else begin
      last_r <= sync_r;
      cnt_r <= changed ? 32'h0 : (settled ? cnt_r : cnt_r + 32'h1);
      if (settled) begin
        clean_r <= last_r;
      end
    end
  end

  assign clean = clean_r;

endmodule : boac_debounce

/* File: core/boac_top.sv */
// Beacon option switch decode, alarm generation, indicators and APB registers.
// Assumes switches, jumpers and the other board pins arrive asynchronously; the APB port is on mclk.
`timescale 1ns/100ps
module boac_top #(
  parameter longint PHOTO_TIMEOUT_CYC = boac_pkg::PHOTO_TIMEOUT_CYC,
  parameter int DEBOUNCE_CYC = boac_pkg::DEBOUNCE_CYC,
  parameter int LED_PULSE_CYC = boac_pkg::LED_PULSE_CYC,
  parameter longint SYNC_PERIOD_CYC = boac_pkg::SYNC_PERIOD_CYC,
  parameter int SYNC_WIDTH_CYC = boac_pkg::SYNC_WIDTH_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Board pins
  input wire logic [6:0] option_sw,
  input wire logic mode_source_jumper,
  input wire logic photocell,
  input wire logic [2:0] markers_detected,
  input wire logic flash_valid,
  input wire logic marker_drive,
  input wire logic uart_tx_act,
  input wire logic uart_rx_act,
  input wire logic modem_dcd,
  // Master/slave sync line, open drain
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic fire_flash,
  output logic rs485_enable,
  output logic modem_enable,
  output logic [2:0] rs485_address,
  output boac_pkg::boac_led_t leds
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [7:0] sw_clean;
  logic [6:0] async_meta_r;
  logic [6:0] async_sync_r;
  logic [2:0] mk_meta_r;
  logic [2:0] mk_sync_r;

  boac_debounce #(
    .W(8),
    .CYC(DEBOUNCE_CYC)
  ) u_debounce (
    .mclk(mclk),
    .reset(reset),
    .raw({mode_source_jumper, option_sw}),
    .clean(sw_clean)
  );

  always_ff @(posedge mclk) begin
    async_meta_r <= {marker_drive, photocell, flash_valid, uart_tx_act, uart_rx_act,
                     modem_dcd, sync_in};
    async_sync_r <= async_meta_r;
    mk_meta_r <= markers_detected;
    mk_sync_r <= mk_meta_r;
  end

  wire marker_s = async_sync_r[6];
  wire photo_s = async_sync_r[5];
  wire flash_s = async_sync_r[4];
  wire tx_s = async_sync_r[3];
  wire rx_s = async_sync_r[2];
  wire dcd_s = async_sync_r[1];
  wire sync_in_s = async_sync_r[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [boac_pkg::IRQ_W-1:0] irq_stat_r;
  logic [boac_pkg::IRQ_W-1:0] irq_stat_nxt;
  logic [boac_pkg::IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;

  wire base_model = ctrl_r[boac_pkg::CTRL_BASE_MODEL];
  wire night_intensity_error = ctrl_r[boac_pkg::CTRL_NIGHT_INTENSITY_ERROR];

  // ----------------------------------------------------------------
  // Option decode
  // ----------------------------------------------------------------
  boac_pkg::boac_cfg_t cfg;
  assign cfg.alarm_report = sw_clean[0];
  assign cfg.address = base_model ? 3'h0 : sw_clean[3:1];
  assign cfg.markers = boac_pkg::boac_marker_count(sw_clean[6:4]);
  assign cfg.slave_mode = sw_clean[7];

  wire addressed = (cfg.address != 3'h0);
  assign rs485_address = cfg.address;
  // Service tool over RS-232 relies on this being off with address zero
  assign rs485_enable = addressed;
  assign modem_enable = !addressed;

  // ----------------------------------------------------------------
  // Alarms
  // ----------------------------------------------------------------
  boac_pkg::boac_alarm_t alarm;
  logic [63:0] photo_cnt_r;
  logic photo_last_r;
  logic photo_alarm_r;
  wire photo_edge = photo_s ^ photo_last_r;
  wire photo_expired = (photo_cnt_r >= 64'(PHOTO_TIMEOUT_CYC - 1));

  // Slaves take day/night from the master, so only the master watches its photocell
  always_ff @(posedge mclk) begin
    if (reset) begin
      photo_cnt_r <= 64'h0;
      photo_last_r <= 1'b0;
      photo_alarm_r <= 1'b0;
    end else begin
      photo_last_r <= photo_s;
      if (photo_edge || cfg.slave_mode) begin
        photo_cnt_r <= 64'h0;
        photo_alarm_r <= 1'b0;
      end else if (photo_expired) begin
        photo_alarm_r <= 1'b1;
      end else begin
        photo_cnt_r <= photo_cnt_r + 64'h1;
      end
    end
  end

  assign alarm.photo = photo_alarm_r;
  assign alarm.marker = (mk_sync_r < cfg.markers);
  assign alarm.red = night_intensity_error | alarm.photo;

  // ----------------------------------------------------------------
  // Sync line
  // ----------------------------------------------------------------
  logic [63:0] sync_cnt_r;
  logic sync_last_r;
  wire sync_wrap = (sync_cnt_r >= 64'(SYNC_PERIOD_CYC - 1));
  wire master_pulse = !cfg.slave_mode && ctrl_r[boac_pkg::CTRL_SYNC_GEN] &&
                      (sync_cnt_r < 64'(SYNC_WIDTH_CYC));

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_cnt_r <= 64'h0;
      sync_last_r <= 1'b0;
    end else begin
      sync_cnt_r <= sync_wrap ? 64'h0 : sync_cnt_r + 64'h1;
      sync_last_r <= sync_in_s;
    end
  end

  // Line pulled low by the master pulse or by a forwarded red alarm level
  assign sync_out = 1'b0;
  assign sync_oe = master_pulse || (cfg.alarm_report && alarm.red);
  assign fire_flash = sync_in_s && !sync_last_r;

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic [31:0] tx_led_cnt_r;
  logic [31:0] rx_led_cnt_r;
  logic [31:0] fl_led_cnt_r;
  logic [2:0] act_last_r;
  boac_pkg::boac_led_t leds_r;
  wire tx_rise = tx_s && !act_last_r[0];
  wire rx_rise = rx_s && !act_last_r[1];
  wire fl_rise = flash_s && !act_last_r[2];

  function automatic logic [31:0] led_next(input logic start, input logic [31:0] cnt);
    led_next = start ? 32'(LED_PULSE_CYC) : ((cnt != 32'h0) ? cnt - 32'h1 : 32'h0);
  endfunction : led_next

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_led_cnt_r <= 32'h0;
      rx_led_cnt_r <= 32'h0;
      fl_led_cnt_r <= 32'h0;
      act_last_r <= 3'h0;
      leds_r <= '0;
    end else begin
      act_last_r <= {flash_s, rx_s, tx_s};
      tx_led_cnt_r <= led_next(tx_rise, tx_led_cnt_r);
      rx_led_cnt_r <= led_next(rx_rise, rx_led_cnt_r);
      fl_led_cnt_r <= led_next(fl_rise, fl_led_cnt_r);
      leds_r.tx <= tx_s || (tx_led_cnt_r != 32'h0);
      leds_r.rx <= rx_s || (rx_led_cnt_r != 32'h0);
      leds_r.flash_det <= flash_s || (fl_led_cnt_r != 32'h0);
      leds_r.marker_out <= marker_s;
      leds_r.dcd <= dcd_s && modem_enable;
      leds_r.red_alarm <= alarm.red;
      leds_r.photo_alarm <= alarm.photo;
      leds_r.marker_alarm <= alarm.marker;
    end
  end

  assign leds = leds_r;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] alarm_last_r;
  wire [boac_pkg::IRQ_W-1:0] irq_events = {fl_rise,
                                           alarm.red && !alarm_last_r[2],
                                           alarm.photo && !alarm_last_r[1],
                                           alarm.marker && !alarm_last_r[0]};

  // ----------------------------------------------------------------
  // APB slave, zero wait state
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = (paddr == boac_pkg::REG_CTRL);
  wire hit_cfg = (paddr == boac_pkg::REG_CFG);
  wire hit_state = (paddr == boac_pkg::REG_STATE);
  wire hit_stat = (paddr == boac_pkg::REG_IRQ_STAT);
  wire hit_mask = (paddr == boac_pkg::REG_IRQ_MASK);
  wire mapped = hit_ctrl || hit_cfg || hit_state || hit_stat || hit_mask;
  wire [31:0] cfg_word = {24'h0, cfg.slave_mode, cfg.markers, cfg.address, cfg.alarm_report};
  wire [31:0] state_word = {22'h0, addressed, dcd_s, mk_sync_r, photo_s,
                            alarm.marker, alarm.photo, alarm.red, sync_oe};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_cfg ? cfg_word :
                       hit_state ? state_word :
                       hit_stat ? {28'h0, irq_stat_r} :
                       hit_mask ? {28'h0, irq_mask_r} : 32'h0;

  // Only bits already returned to software are cleared; an event arriving
  // between setup and access survives, and a new event wins over the clear
  assign irq_stat_nxt = ((rd && hit_stat) ? (irq_stat_r & ~prdata_r[boac_pkg::IRQ_W-1:0]) :
                         irq_stat_r) | irq_events;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= boac_pkg::CTRL_RESET;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      alarm_last_r <= 3'h0;
      prdata_r <= 32'h0;
    end else begin
      alarm_last_r <= {alarm.red, alarm.photo, alarm.marker};
      irq_stat_r <= irq_stat_nxt;
      if (wr && hit_ctrl) begin
        ctrl_r <= {29'h0, pwdata[2:0]};
      end
      if (wr && hit_mask) begin
        irq_mask_r <= pwdata[boac_pkg::IRQ_W-1:0];
      end
      // Read data is taken in the setup cycle so prdata comes straight from a flop
      prdata_r <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence red_up_s;
    !alarm.red ##1 alarm.red;
  endsequence

  alarm_forward_a: assert property (@(posedge mclk) disable iff (reset)
    (cfg.alarm_report && alarm.red) |-> sync_oe)
    else $error("red alarm not forwarded");
  alarm_local_a: assert property (@(posedge mclk) disable iff (reset)
    (!cfg.alarm_report && !master_pulse) |-> !sync_oe)
    else $error("sync line driven while isolated");
  port_select_a: assert property (@(posedge mclk) disable iff (reset)
    rs485_enable == (rs485_address != 3'h0) && modem_enable == !rs485_enable)
    else $error("serial channel select wrong");
  base_addr_a: assert property (@(posedge mclk) disable iff (reset)
    base_model |-> (rs485_address == 3'h0 && !rs485_enable))
    else $error("address used on base model");
  marker_count_a: assert property (@(posedge mclk) disable iff (reset)
    cfg.markers <= 3'h6)
    else $error("marker count above six");
  marker_led_a: assert property (@(posedge mclk) disable iff (reset)
    (mk_sync_r < cfg.markers) |=> leds.marker_alarm)
    else $error("marker alarm indicator missing");
  photo_hold_a: assert property (@(posedge mclk) disable iff (reset)
    photo_edge |=> !alarm.photo)
    else $error("photocell alarm despite transition");
  red_combine_a: assert property (@(posedge mclk) disable iff (reset)
    red_up_s |-> (night_intensity_error || alarm.photo) ##1 leds.red_alarm)
    else $error("red alarm not derived or shown");
  flash_led_a: assert property (@(posedge mclk) disable iff (reset)
    fl_rise |=> leds.flash_det [*2])
    else $error("flash indicator not lit");
  dcd_led_a: assert property (@(posedge mclk) disable iff (reset)
    (dcd_s && modem_enable) |=> leds.dcd)
    else $error("dcd indicator dropped");
  stat_sticky_a: assert property (@(posedge mclk) disable iff (reset)
    (irq_events != '0) |=> ((irq_stat_r & $past(irq_events)) == $past(irq_events)))
    else $error("interrupt event lost");

  // Indicator, role, sync-line, decode and bus checks
  sequence sync_rise_s;
    !sync_in_s ##1 sync_in_s;
  endsequence

  marker_out_a: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> (leds.marker_out == $past(marker_s)))
    else $error("marker output indicator wrong");
  tx_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    tx_rise |=> leds.tx [*2])
    else $error("transmit indicator not pulsed");
  rx_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    rx_rise |=> leds.rx [*2])
    else $error("receive indicator not pulsed");
  dcd_off_a: assert property (@(posedge mclk) disable iff (reset)
    !dcd_s |=> !leds.dcd)
    else $error("dcd indicator lit without carrier");
  fire_edge_a: assert property (@(posedge mclk) disable iff (reset)
    sync_rise_s |-> fire_flash)
    else $error("sync pulse did not fire flash");
  fire_once_a: assert property (@(posedge mclk) disable iff (reset)
    fire_flash |=> !fire_flash)
    else $error("flash fired twice on one pulse");
  slave_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    cfg.slave_mode |-> !master_pulse)
    else $error("slave generating sync pulse");
  photo_slave_a: assert property (@(posedge mclk) disable iff (reset)
    cfg.slave_mode |=> !alarm.photo)
    else $error("slave raised photocell alarm");
  addr_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (sw_clean[3:1] == 3'h0) |-> (!rs485_enable && modem_enable))
    else $error("multidrop port active at address zero");
  marker_six_a: assert property (@(posedge mclk) disable iff (reset)
    (sw_clean[6:4] == 3'h7) |-> (cfg.markers == 3'h6))
    else $error("all-on marker pattern not six");
  rd_idle_a: assert property (@(posedge mclk) disable iff (reset)
    !psel |-> (prdata == 32'h0))
    else $error("read data outside a transfer");

endmodule : boac_top

/* File: dv/boac_peer.sv */
// Peer controller model standing on the shared master/slave sync line.
// Assumes a wired-OR line: asserted while any party pulls it, idle when released.
`timescale 1ns/100ps
module boac_peer #(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic fire_req,
  input wire logic dut_oe,
  output logic line
);
  int cnt = 0;

  // A peer acting as master pulls the line for a fixed width, then lets go
  always_ff @(posedge mclk) begin
    if (fire_req && cnt == 0) begin
      cnt <= WIDTH;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  // Released line falls to its idle level, never keeps the last drive
  assign line = (cnt != 0) | dut_oe;
endmodule : boac_peer

/* File: dv/tb_beacon_option_alarm_config.sv */
// Self-checking bench for the beacon option and alarm block.
// Assumes shortened timing parameters and one peer model on the sync line.
`timescale 1ns/100ps
module tb_beacon_option_alarm_config;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, irq, sync_line, sync_out, sync_oe, fire_flash;
  logic rs485_enable, modem_enable;
  logic [6:0] option_sw = 7'h00, sw;
  logic mode_source_jumper = 0, photocell = 0, flash_valid = 0, marker_drive = 0;
  logic uart_tx_act = 0, uart_rx_act = 0, modem_dcd = 0, fire_req = 0;
  logic [2:0] markers_detected = 3'h0, rs485_address, md;
  boac_pkg::boac_led_t leds;
  int mismatches = 0, checked = 0, n, cnt;
  integer seed = 32'h81aa;

  boac_top #(.PHOTO_TIMEOUT_CYC(100), .DEBOUNCE_CYC(4), .LED_PULSE_CYC(8),
    .SYNC_PERIOD_CYC(50), .SYNC_WIDTH_CYC(3)) uut (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .option_sw(option_sw),
    .mode_source_jumper(mode_source_jumper), .photocell(photocell),
    .markers_detected(markers_detected), .flash_valid(flash_valid),
    .marker_drive(marker_drive), .uart_tx_act(uart_tx_act), .uart_rx_act(uart_rx_act),
    .modem_dcd(modem_dcd), .sync_in(sync_line), .sync_out(sync_out), .sync_oe(sync_oe),
    .fire_flash(fire_flash), .rs485_enable(rs485_enable), .modem_enable(modem_enable),
    .rs485_address(rs485_address), .leds(leds));

  boac_peer peer (.mclk(mclk), .fire_req(fire_req), .dut_oe(sync_oe),
    .line(sync_line));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc

  // Request held until pready is seen high; data and error taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      $display("ERROR %0t bus wait ran out", $time);
      stop_test();
    end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  function automatic logic [2:0] mk_cnt(input logic [2:0] s);
    return (s == 3'h7) ? 3'h6 : s;
  endfunction : mk_cnt

  function automatic logic [31:0] exp_cfg(input logic [6:0] s, input logic slv);
    return {24'h0, slv, mk_cnt(s[6:4]), s[3:1], s[0]};
  endfunction : exp_cfg

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (8) @(posedge mclk);
    reset <= 0;
    cyc(2);
    chk(32'(leds), 32'h0, "leds after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    apb(0, boac_pkg::REG_CTRL, 32'h0);
    chk(rd, boac_pkg::CTRL_RESET, "ctrl reset value");
    apb(0, boac_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd, 32'h0, "mask reset value");
    apb(1, 8'h14, 32'hffff_ffff);
    chk(32'(err), 32'h1, "unmapped write error");
    apb(0, 8'h14, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    // Corner patterns first, then random switch settings
    for (n = 0; n < 10; n++) begin
      r = $random(seed);
      sw = (n == 0) ? 7'h7f : (n == 1) ? 7'h00 : r[6:0];
      md = r[9:7];
      option_sw <= sw; mode_source_jumper <= n[0]; markers_detected <= md;
      cyc(16);
      apb(0, boac_pkg::REG_CFG, 32'h0);
      chk(rd, exp_cfg(sw, n[0]), "cfg decode");
      chk(32'({rs485_enable, modem_enable}), 32'({sw[3:1] != 0, sw[3:1] == 0}), "port");
      chk(32'(rs485_address), 32'(sw[3:1]), "address");
      chk(32'(leds.marker_alarm), 32'(md < mk_cnt(sw[6:4])), "marker alarm");
    end
    option_sw <= 7'h0a;
    cyc(16);
    apb(1, boac_pkg::REG_CTRL, 32'h1);
    cyc(3);
    chk(32'({rs485_enable, modem_enable}), 32'h1, "base model port");
    option_sw <= 7'h0b;
    cyc(2);
    option_sw <= 7'h0a;
    cyc(16);
    apb(0, boac_pkg::REG_CFG, 32'h0);
    // Base model is still set, so the address field reads zero
    chk(rd, exp_cfg(7'h0a & 7'h71, 1'b1), "glitch filtered");
    // Red alarm forwarded only with the report switch on; slave keeps timer idle
    option_sw <= 7'h01; mode_source_jumper <= 1;
    cyc(16);
    apb(1, boac_pkg::REG_CTRL, 32'h2);
    cyc(6);
    chk(32'({leds.red_alarm, sync_oe}), 32'h3, "red forwarded");
    option_sw <= 7'h00;
    cyc(16);
    chk(32'({leds.red_alarm, sync_oe}), 32'h2, "red isolated");
    apb(1, boac_pkg::REG_CTRL, 32'h0);
    mode_source_jumper <= 0; photocell <= 1;
    cyc(66);
    chk(32'(leds.photo_alarm), 32'h0, "photo early");
    cyc(50);
    chk(32'({leds.photo_alarm, leds.red_alarm}), 32'h3, "photo timeout");
    photocell <= 0;
    cyc(6);
    // Interrupt: flash event masked in, then masked out
    apb(1, boac_pkg::REG_IRQ_MASK, 32'h8);
    apb(0, boac_pkg::REG_IRQ_STAT, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0, "irq cleared");
    flash_valid <= 1;
    cyc(1);
    flash_valid <= 0;
    cyc(6);
    chk(32'({leds.flash_det, irq}), 32'h3, "flash seen");
    apb(0, boac_pkg::REG_IRQ_STAT, 32'h0);
    chk(32'(rd[3]), 32'h1, "flash status");
    cyc(2);
    chk(32'(irq), 32'h0, "read clears");
    apb(1, boac_pkg::REG_IRQ_MASK, 32'h0);
    flash_valid <= 1;
    cyc(1);
    flash_valid <= 0;
    cyc(20);
    chk(32'({leds.flash_det, irq}), 32'h0, "masked, led expired");
    apb(0, boac_pkg::REG_IRQ_STAT, 32'h0);
    chk(32'(rd[3]), 32'h1, "masked status");
    // Service traffic only with the address switches all off
    {marker_drive, uart_tx_act, uart_rx_act, modem_dcd} <= 4'hf;
    cyc(6);
    chk(32'({leds.marker_out, leds.tx, leds.rx, leds.dcd}), 32'hf, "lit");
    cyc(24);
    chk(32'({leds.marker_out, leds.dcd}), 32'h3, "held");
    {marker_drive, uart_tx_act, uart_rx_act, modem_dcd} <= 4'h0;
    cyc(20);
    chk(32'({leds.marker_out, leds.tx, leds.rx, leds.dcd}), 32'h0, "dark");
    // Peer sync pulse fires exactly once; own generator gives fixed duty
    fire_req <= 1;
    cyc(1);
    fire_req <= 0;
    cnt = 0;
    repeat (10) begin
      @(posedge mclk);
      if (fire_flash === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'h1, "peer sync fire");
    apb(1, boac_pkg::REG_CTRL, 32'h4);
    cnt = 0;
    repeat (100) begin
      @(posedge mclk);
      if (sync_oe === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'h6, "sync generator duty");
    chk(32'(sync_out), 32'h0, "sync drive level");
    stop_test();
  end
endmodule : tb_beacon_option_alarm_config
